// ==== src/addr_status_cfg.svh ====
`ifndef ADDR_STATUS_CFG_SVH
`define ADDR_STATUS_CFG_SVH

// register byte addresses on the axi4-lite port
`define SLOT1_STATUS_ADDR   8'h00
`define ADDR_STATE_ADDR     8'h04
`define SLOT1_CONFIG_ADDR   8'h08
`define MODE_CTRL_ADDR      8'h0c
`define CMD_ADDR            8'h10
`define MATCH_STATUS_ADDR   8'h14

// field positions
`define EOI_BIT             7
`define TDIS_BIT            6
`define LDIS_BIT            5
`define CIC_BIT             7
`define ATN_BIT             6
`define SERIAL_POLL_MODE_STATE_BIT            5
`define LEGACY_BIT          0
`define DUAL_BIT            1
`define CMD_CHIP_RESET_BIT  0

// reset values
`define SLOT1_CONFIG_RST    8'h60
`define MODE_CTRL_RST       2'h0

// bus byte bases
`define SEC_BASE            8'h60
`define TALK_BASE           8'h40
`define LISTEN_BASE         8'h20

// bus commands
`define SPE_CMD             8'h18
`define SPD_CMD             8'h19

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== src/addr_status_pkg.sv ====
package addr_status_pkg;
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rd_state_t;
endpackage

// ==== src/sync2.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// two flop level synchroniser
// ----------------------------------------
module sync2 (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end

    // synchronous reset to idle level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.sync;
endmodule

// ==== src/gpib_address_status_readback.sv ====
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "addr_status_cfg.svh"

// Function
// - bit 7 of the slot status register holds the eoi level taken with each accepted byte.
// - the eoi bit is refreshed on every accepted byte.
// - the eoi bit clears on the chip reset command unless a byte is accepted in the same cycle.
// - the slot status register shows the secondary slot or the minor primary slot per mode.
// - talker disable in bit 6 blocks the slot talk match and talker function.
// - listener disable in bit 5 blocks the slot listen match and listener function.
// - outside dual primary mode the slot address matches a secondary byte equal to 60h plus its five bits.
// - in dual primary mode minor talk is 40h plus the value and minor listen 20h plus it.
// - the controller bit 7 is the inverse of being in either controller idle state.
// - bit 6 shows the live atn level, zero while atn is asserted.
// - serial poll mode sets on an accepted serial poll enable and lets the talker poll.
// - serial poll mode clears on serial poll disable, power-on reset or interface clear.
module gpib_address_status_readback
    import addr_status_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // gpib side, pins are asynchronous
    input  wire logic [7:0]  dio_n,
    input  wire logic        atn_n,
    input  wire logic        eoi_n,
    input  wire logic        ifc_n,
    // from handshake and controller logic on aclk
    input  wire logic        byte_accept,
    input  wire logic        controller_idle,
    input  wire logic        controller_addr_idle,
    // match results
    output logic             slot_talk_match,
    output logic             slot_listen_match,
    output logic             serial_poll_talk_en
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic        eoi;
        logic        serial_poll_mode_state;
        logic [7:0]  cfg;
        logic [1:0]  mode;
        logic        aw_seen;
        logic        w_seen;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        rd_state_t   rd;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        talk_m;
        logic        listen_m;
        logic        sp_en;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [7:0] dio_s;
    logic       atn_s;
    logic       eoi_s;
    logic       ifc_s;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_dio
        sync2 u_dio (
            .aclk    (aclk),
            .aresetn (aresetn),
            .din     (~dio_n[i]),
            .dout    (dio_s[i])
        );
    end

    sync2 u_atn (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (~atn_n),
        .dout    (atn_s)
    );

    sync2 u_eoi (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (~eoi_n),
        .dout    (eoi_s)
    );

    sync2 u_ifc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (~ifc_n),
        .dout    (ifc_s)
    );

    // ----------------------------------------
    // register views
    // ----------------------------------------
    logic [7:0] slot_view;
    logic [7:0] state_view;
    logic       cic;
    logic [7:0] base_talk;
    logic [7:0] base_listen;

    // slot view shows the same five bits in both modes, only meaning differs
    always_comb begin
        slot_view                = s_q.cfg;
        slot_view[`EOI_BIT]      = s_q.eoi;
        cic                      = ~(controller_idle | controller_addr_idle);
        state_view               = 8'h00;
        state_view[`CIC_BIT]     = cic;
        state_view[`ATN_BIT]     = ~atn_s;
        state_view[`SERIAL_POLL_MODE_STATE_BIT]    = s_q.serial_poll_mode_state;
        base_talk   = s_q.mode[`DUAL_BIT] ? `TALK_BASE   : `SEC_BASE;
        base_listen = s_q.mode[`DUAL_BIT] ? `LISTEN_BASE : `SEC_BASE;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic       cmd_byte;
    logic       do_write;
    logic       chip_rst;
    logic [7:0] addr_val;

    always_comb begin
        s_d      = s_q;
        addr_val = {3'h0, s_q.cfg[4:0]};
        cmd_byte = byte_accept & atn_s;
        do_write = 1'b0;
        chip_rst = 1'b0;

        // eoi latch, command clear wins only without a byte in the cycle
        if (byte_accept) begin
            s_d.eoi = eoi_s;
        end

        // serial poll mode, clear sources beat a simultaneous set
        if (cmd_byte && dio_s == `SPE_CMD) begin
            s_d.serial_poll_mode_state = 1'b1;
        end
        if ((cmd_byte && dio_s == `SPD_CMD) || ifc_s) begin
            s_d.serial_poll_mode_state = 1'b0;
        end

        // slot matching on accepted command bytes, taken with atn asserted
        s_d.talk_m   = cmd_byte & ~s_q.cfg[`TDIS_BIT]
                     & (dio_s == 8'(base_talk + addr_val));
        s_d.listen_m = cmd_byte & ~s_q.cfg[`LDIS_BIT]
                     & (dio_s == 8'(base_listen + addr_val));
        s_d.sp_en    = s_q.serial_poll_mode_state & ~s_q.cfg[`TDIS_BIT];

        // write channel: address and data taken in either order
        s_d.awready = 1'b0;
        s_d.wready  = 1'b0;
        if (s_axi_awvalid && !s_q.aw_seen && !s_q.bvalid) begin
            s_d.aw_seen = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
            s_d.awready = 1'b1;
        end
        if (s_axi_wvalid && !s_q.w_seen && !s_q.bvalid) begin
            s_d.w_seen = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
            s_d.wready = 1'b1;
        end
        // awready and wready are pulses; the seen flags block a second take
        if (s_q.awready) begin
            s_d.awready = 1'b0;
        end
        if (s_q.wready) begin
            s_d.wready = 1'b0;
        end

        if (s_q.aw_seen && s_q.w_seen && !s_q.bvalid) begin
            do_write    = 1'b1;
            s_d.aw_seen = 1'b0;
            s_d.w_seen  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = `RESP_OKAY;
            unique case (s_q.aw_addr)
                `SLOT1_CONFIG_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cfg = {1'b0, s_q.w_data[6:0]};
                    end
                end
                `MODE_CTRL_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        s_d.mode = s_q.w_data[1:0];
                    end
                end
                `CMD_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        chip_rst = s_q.w_data[`CMD_CHIP_RESET_BIT];
                    end
                end
                // status registers ignore writes but answer okay
                `SLOT1_STATUS_ADDR, `ADDR_STATE_ADDR, `MATCH_STATUS_ADDR: begin
                    s_d.bresp = `RESP_OKAY;
                end
                default: begin
                    s_d.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // chip reset clears eoi unless a byte lands in the same cycle
        if (chip_rst && !byte_accept) begin
            s_d.eoi = 1'b0;
        end

        // read channel
        s_d.arready = 1'b0;
        unique case (s_q.rd)
            RD_IDLE: begin
                if (s_axi_arvalid && !s_q.arready) begin
                    s_d.arready = 1'b1;
                    s_d.rvalid  = 1'b1;
                    s_d.rd      = RD_RESP;
                    s_d.rresp   = `RESP_OKAY;
                    s_d.rdata   = 32'h0000_0000;
                    unique case (s_axi_araddr)
                        `SLOT1_STATUS_ADDR: s_d.rdata[7:0] = slot_view;
                        `ADDR_STATE_ADDR: begin
                            if (s_q.mode[`LEGACY_BIT]) begin
                                s_d.rdata[7:0] = state_view;
                            end else begin
                                s_d.rresp = `RESP_SLVERR;
                            end
                        end
                        `SLOT1_CONFIG_ADDR: s_d.rdata[7:0] = s_q.cfg;
                        `MODE_CTRL_ADDR:    s_d.rdata[1:0] = s_q.mode;
                        `CMD_ADDR:          s_d.rdata      = 32'h0000_0000;
                        `MATCH_STATUS_ADDR: s_d.rdata[2:0] = {s_q.sp_en, s_q.listen_m,
                                                              s_q.talk_m};
                        default:            s_d.rresp      = `RESP_SLVERR;
                    endcase
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    s_d.rvalid = 1'b0;
                    s_d.rd     = RD_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // power-on reset clears eoi and serial poll mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q      <= '0;
            s_q.cfg  <= `SLOT1_CONFIG_RST;
            s_q.mode <= `MODE_CTRL_RST;
            s_q.rd   <= RD_IDLE;
            s_q.serial_poll_mode_state <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs, all from flops
    // ----------------------------------------
    assign s_axi_awready       = s_q.awready;
    assign s_axi_wready        = s_q.wready;
    assign s_axi_bvalid        = s_q.bvalid;
    assign s_axi_bresp         = s_q.bresp;
    assign s_axi_arready       = s_q.arready;
    assign s_axi_rvalid        = s_q.rvalid;
    assign s_axi_rdata         = s_q.rdata;
    assign s_axi_rresp         = s_q.rresp;
    assign slot_talk_match     = s_q.talk_m;
    assign slot_listen_match   = s_q.listen_m;
    assign serial_poll_talk_en = s_q.sp_en;

endmodule

// ==== verif/addr_status_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// bus handshake and match checks
// ----------------------------------------
module addr_status_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        byte_accept,
    input wire logic        slot_talk_match,
    input wire logic        slot_listen_match
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // fresh write offer, nothing pending or answered yet
    sequence wr_offer;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence wr_ack;
        s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
    endsequence

    wr_answer_a: assert property (wr_offer |=> wr_ack) else $error("write answer late");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
    rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready too long");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    talk_cause_a: assert property (slot_talk_match |-> $past(byte_accept))
        else $error("talk match without byte");
    listen_cause_a: assert property (slot_listen_match |-> $past(byte_accept))
        else $error("listen match without byte");
endmodule

bind gpib_address_status_readback addr_status_sva addr_status_sva_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .byte_accept(byte_accept),
    .slot_talk_match(slot_talk_match), .slot_listen_match(slot_listen_match)
);

// ==== verif/gpib_far_end.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// bus controller and instruments
// ----------------------------------------
module gpib_far_end (
    input  wire logic       aclk,
    output logic      [7:0] dio_n,
    output logic            atn_n,
    output logic            eoi_n,
    output logic            ifc_n,
    output logic            byte_accept
);
    // released lines float high through the bus pull-ups
    initial begin
        dio_n = 8'hff;
        atn_n = 1'b1;
        eoi_n = 1'b1;
        ifc_n = 1'b1;
        byte_accept = 1'b0;
    end
    // pins settle three edges before the acceptor takes them
    task automatic put_byte(input logic [7:0] b, input logic atn, input logic eoi);
        @(posedge aclk);
        dio_n <= ~b;
        atn_n <= ~atn;
        eoi_n <= ~eoi;
        repeat (3) @(posedge aclk);
        byte_accept <= 1'b1;
        @(posedge aclk);
        byte_accept <= 1'b0;
        dio_n <= 8'hff;
        eoi_n <= 1'b1;
        atn_n <= 1'b1;
    endtask
    task automatic set_atn(input logic a);
        @(posedge aclk);
        atn_n <= ~a;
    endtask
    task automatic pulse_ifc();
        @(posedge aclk);
        ifc_n <= 1'b0;
        repeat (4) @(posedge aclk);
        ifc_n <= 1'b1;
    endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`include "addr_status_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        controller_idle = 1'b0, controller_addr_idle = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  dio_n;
    logic        atn_n, eoi_n, ifc_n, byte_accept;
    logic        slot_talk_match, slot_listen_match, serial_poll_talk_en;
    logic [7:0]  seed = 8'h1c, cfg, b;
    logic        eoi_exp = 1'b0;
    logic [1:0]  em;
    int          error_cnt = 0, compares = 0, cyc = 0, tm_cnt = 0, lm_cnt = 0, t0, l0;

    always #4 aclk = ~aclk;
    gpib_address_status_readback gpib_address_status_readback_i (.*);
    gpib_far_end gpib_far_end_i (.aclk(aclk), .dio_n(dio_n), .atn_n(atn_n), .eoi_n(eoi_n),
        .ifc_n(ifc_n), .byte_accept(byte_accept));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] exp_state(input logic ci, cai, atn_lvl, serial_poll_mode_state);
        return {~(ci | cai), atn_lvl, serial_poll_mode_state, 5'h00};
    endfunction
    function automatic logic [1:0] exp_match(input logic [7:0] v, input logic dual,
                                             input logic [6:0] c);
        logic [7:0] ta, la;
        ta = (dual ? `TALK_BASE : `SEC_BASE) + {3'h0, c[4:0]};
        la = (dual ? `LISTEN_BASE : `SEC_BASE) + {3'h0, c[4:0]};
        return {!c[5] && v == la, !c[6] && v == ta};
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        // address channel is released once taken, data waited for on its own
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er)
        `CHK(s_axi_rdata, {24'h0, ed})
    endtask
    // extra edges let synchronisers and registered matches land
    task automatic send(input logic [7:0] v, input logic atn, input logic eoi);
        gpib_far_end_i.put_byte(v, atn, eoi);
        repeat (3) @(posedge aclk);
    endtask
    task automatic end_sim();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // pulse counters and hang guard
    // ----------------------------------------
    always @(posedge aclk) begin
        tm_cnt += slot_talk_match;
        lm_cnt += slot_listen_match;
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(`SLOT1_STATUS_ADDR, 8'h60, `RESP_OKAY);
        axi_rd(`ADDR_STATE_ADDR, 8'h00, `RESP_SLVERR);
        axi_wr(`SLOT1_STATUS_ADDR, 32'hff, `RESP_OKAY);
        axi_rd(`SLOT1_STATUS_ADDR, 8'h60, `RESP_OKAY);
        axi_wr(8'h1c, 32'h0, `RESP_SLVERR);
        axi_wr(`MODE_CTRL_ADDR, 32'h1, `RESP_OKAY);
        // every idle combination, atn asserted on half of them
        for (int i = 0; i < 4; i++) begin
            controller_idle <= i[0];
            controller_addr_idle <= i[1];
            gpib_far_end_i.set_atn(i[1]);
            repeat (4) @(posedge aclk);
            axi_rd(`ADDR_STATE_ADDR, exp_state(i[0], i[1], ~i[1], 1'b0), `RESP_OKAY);
        end
        gpib_far_end_i.set_atn(1'b0);
        // back to controller active so later state reads expect cic set
        controller_idle <= 1'b0;
        controller_addr_idle <= 1'b0;
        // random slot settings in both addressing modes
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            cfg = seed;
            axi_wr(`MODE_CTRL_ADDR, {30'h0, k[0], 1'b1}, `RESP_OKAY);
            axi_wr(`SLOT1_CONFIG_ADDR, {24'h0, cfg}, `RESP_OKAY);
            seed = lfsr(seed);
            send(seed, 1'b0, seed[7]);
            eoi_exp = seed[7];
            axi_rd(`SLOT1_STATUS_ADDR, {eoi_exp, cfg[6:0]}, `RESP_OKAY);
            for (int j = 0; j < 3; j++) begin
                b = (j == 0 ? 8'h40 : j == 1 ? 8'h20 : 8'h60) + {3'h0, cfg[4:0]};
                t0 = tm_cnt;
                l0 = lm_cnt;
                send(b, 1'b1, 1'b0);
                em = exp_match(b, k[0], cfg[6:0]);
                `CHK(tm_cnt - t0, int'(em[0]))
                `CHK(lm_cnt - l0, int'(em[1]))
            end
        end
        // chip reset drops a latched eoi
        axi_wr(`SLOT1_CONFIG_ADDR, 32'h05, `RESP_OKAY);
        send(8'h55, 1'b0, 1'b1);
        axi_rd(`SLOT1_STATUS_ADDR, 8'h85, `RESP_OKAY);
        axi_wr(`CMD_ADDR, 32'h1, `RESP_OKAY);
        axi_rd(`SLOT1_STATUS_ADDR, 8'h05, `RESP_OKAY);
        // poll mode: data byte with disable code must not clear it
        send(`SPE_CMD, 1'b1, 1'b0);
        axi_rd(`ADDR_STATE_ADDR, exp_state(1'b0, 1'b0, 1'b1, 1'b1), `RESP_OKAY);
        `CHK(serial_poll_talk_en, 1'b1)
        send(`SPD_CMD, 1'b0, 1'b0);
        axi_rd(`ADDR_STATE_ADDR, exp_state(1'b0, 1'b0, 1'b1, 1'b1), `RESP_OKAY);
        send(`SPD_CMD, 1'b1, 1'b0);
        axi_rd(`ADDR_STATE_ADDR, exp_state(1'b0, 1'b0, 1'b1, 1'b0), `RESP_OKAY);
        `CHK(serial_poll_talk_en, 1'b0)
        send(`SPE_CMD, 1'b1, 1'b0);
        gpib_far_end_i.pulse_ifc();
        repeat (4) @(posedge aclk);
        axi_rd(`ADDR_STATE_ADDR, exp_state(1'b0, 1'b0, 1'b1, 1'b0), `RESP_OKAY);
        end_sim();
    end
endmodule
